// ### hw/bpat_core.sv
// card-side transport of command units over the character protocol
// Operation
// - no-data command: status words only
// - decode header: application picks no data, read, write or both
// - read normal: data bytes then status pair
// - read abnormal: status pair only
// - procedure byte equals instruction byte
// - success ends with 90 00
// - bad P1/P2 answers 6A 86
// - write command: status after body and processing
// - two-way normal: send 61 plus length
// - two-way abnormal: status only
// - fetch command handled like read command
// - zero or excess length: 6C plus available
// - short length: data then 61 remainder
`timescale 1ns/1ps
`default_nettype none
`include "bpat_defs.svh"
module bpat_core (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // bytes from the terminal
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_byte_i,
  // bytes to the terminal
  output logic tx_valid_o,
  output logic [7:0] tx_byte_o,
  input wire logic tx_ready_i,
  // received header towards the application
  output logic hdr_valid_o,
  output logic [7:0] hdr_cla_o,
  output logic [7:0] hdr_ins_o,
  output logic [7:0] hdr_p1_o,
  output logic [7:0] hdr_p2_o,
  output logic [7:0] hdr_p3_o,
  // application decision on the header
  input wire logic dec_valid_i,
  input wire bpat_pkg::bpat_dir_type dec_dir_i,
  input wire logic dec_param_ok_i,
  input wire logic dec_normal_i,
  input wire logic [7:0] dec_avail_i,
  input wire logic [7:0] dec_sw1_i,
  input wire logic [7:0] dec_sw2_i,
  // response data from the application
  output logic rd_req_o,
  input wire logic rd_valid_i,
  input wire logic [7:0] rd_byte_i,
  // body data towards the application
  output logic body_valid_o,
  output logic [7:0] body_byte_o,
  // application end of body processing
  input wire logic done_valid_i,
  input wire logic done_normal_i,
  input wire logic [7:0] done_avail_i,
  input wire logic [7:0] done_sw1_i,
  input wire logic [7:0] done_sw2_i
);
  import bpat_pkg::*;

  bpat_state_type state_r;
  bpat_dir_type dir_r;
  logic [2:0] hidx_r;
  logic [8:0] cnt_r;
  logic [7:0] left_r;
  logic [7:0] pend_r;
  logic pend_v_r;
  logic rdwait_r;
  logic busy;
  logic ld;
  logic ld_two;
  logic [7:0] ld_b0;
  logic [7:0] ld_b1;
  logic [7:0] avail;

  // body length: zero in P3 stands for 256 bytes
  function automatic logic [8:0] body_len(input logic [7:0] p3);
    body_len = (p3 == 8'h00) ? 9'h100 : {1'b0, p3};
  endfunction

  // a fetch after 61xx offers what is still pending
  assign avail = (hdr_ins_o == `BPAT_INS_GET_RESPONSE && pend_v_r) ?
                 pend_r : dec_avail_i;

  // header capture: five bytes in order, then one pulse to the app
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hidx_r <= 3'h0;
      hdr_valid_o <= 1'b0;
      hdr_cla_o <= 8'h00;
      hdr_ins_o <= 8'h00;
      hdr_p1_o <= 8'h00;
      hdr_p2_o <= 8'h00;
      hdr_p3_o <= 8'h00;
    end else begin
      hdr_valid_o <= 1'b0;
      if (state_r == BPAT_S_HDR && rx_valid_i) begin
        unique case (hidx_r)
          3'h0: hdr_cla_o <= rx_byte_i;
          3'h1: hdr_ins_o <= rx_byte_i;
          3'h2: hdr_p1_o <= rx_byte_i;
          3'h3: hdr_p2_o <= rx_byte_i;
          default: hdr_p3_o <= rx_byte_i;
        endcase
        if (hidx_r == `BPAT_HDR_LEN - 3'h1) begin
          hidx_r <= 3'h0;
          hdr_valid_o <= 1'b1;
        end else begin
          hidx_r <= hidx_r + 3'h1;
        end
      end
    end
  end

  // what to hand the sender this cycle
  always_comb begin
    ld = 1'b0;
    ld_two = 1'b0;
    ld_b0 = 8'h00;
    ld_b1 = 8'h00;
    unique case (state_r)
      BPAT_S_DEC: begin
        if (dec_valid_i) begin
          ld = 1'b1;
          ld_two = 1'b1;
          if (!dec_param_ok_i) begin
            ld_b0 = `BPAT_SW1_BAD_PARAM;
            ld_b1 = `BPAT_SW2_BAD_PARAM;
          end else if (!dec_normal_i) begin
            ld_b0 = dec_sw1_i;
            ld_b1 = dec_sw2_i;
          end else if (dec_dir_i == BPAT_DIR_NONE) begin
            ld_b0 = `BPAT_SW1_OK;
            ld_b1 = `BPAT_SW2_OK;
          end else if (dec_dir_i == BPAT_DIR_OUT &&
                       (hdr_p3_o == 8'h00 || hdr_p3_o > avail)) begin
            ld_b0 = `BPAT_PB_WRONG_LEN;
            ld_b1 = avail;
          end else begin
            ld_two = 1'b0;
            ld_b0 = hdr_ins_o;
          end
        end
      end
      BPAT_S_DATA: begin
        if (!busy && rdwait_r && rd_valid_i) begin
          ld = 1'b1;
          ld_b0 = rd_byte_i;
        end else if (!busy && !rdwait_r && cnt_r == 9'h000) begin
          ld = 1'b1;
          ld_two = 1'b1;
          ld_b0 = (left_r != 8'h00) ? `BPAT_PB_MORE : `BPAT_SW1_OK;
          ld_b1 = (left_r != 8'h00) ? left_r : `BPAT_SW2_OK;
        end
      end
      BPAT_S_PROC: begin
        if (done_valid_i) begin
          ld = 1'b1;
          ld_two = 1'b1;
          if (!done_normal_i) begin
            ld_b0 = done_sw1_i;
            ld_b1 = done_sw2_i;
          end else if (dir_r == BPAT_DIR_BOTH) begin
            ld_b0 = `BPAT_PB_MORE;
            ld_b1 = done_avail_i;
          end else begin
            ld_b0 = `BPAT_SW1_OK;
            ld_b1 = `BPAT_SW2_OK;
          end
        end
      end
      default: ;
    endcase
  end

  // case sequencing; the terminal may only send a body after our
  // procedure byte, so an early status leaves us waiting for a header
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r <= BPAT_S_HDR;
      dir_r <= BPAT_DIR_NONE;
      cnt_r <= 9'h000;
      left_r <= 8'h00;
      rdwait_r <= 1'b0;
      rd_req_o <= 1'b0;
    end else begin
      rd_req_o <= 1'b0;
      unique case (state_r)
        BPAT_S_HDR: begin
          if (hdr_valid_o) begin
            state_r <= BPAT_S_DEC;
          end
        end
        BPAT_S_DEC: begin
          if (dec_valid_i) begin
            dir_r <= dec_dir_i;
            state_r <= BPAT_S_FIN;
            if (ld && !ld_two && dec_dir_i == BPAT_DIR_OUT) begin
              cnt_r <= {1'b0, hdr_p3_o};
              left_r <= avail - hdr_p3_o;
              state_r <= BPAT_S_DATA;
            end else if (ld && !ld_two) begin
              cnt_r <= body_len(hdr_p3_o);
              state_r <= BPAT_S_BODY;
            end
          end
        end
        BPAT_S_DATA: begin
          if (ld && !ld_two) begin
            rdwait_r <= 1'b0;
            cnt_r <= cnt_r - 9'h001;
          end else if (ld) begin
            state_r <= BPAT_S_FIN;
          end else if (!busy && !rdwait_r && cnt_r != 9'h000) begin
            rd_req_o <= 1'b1; // ask the app for the next byte
            rdwait_r <= 1'b1;
          end
        end
        BPAT_S_BODY: begin
          if (rx_valid_i) begin
            cnt_r <= cnt_r - 9'h001;
            if (cnt_r == 9'h001) begin
              state_r <= BPAT_S_PROC;
            end
          end
        end
        BPAT_S_PROC: begin
          if (done_valid_i) begin
            state_r <= BPAT_S_FIN;
          end
        end
        BPAT_S_FIN: begin
          if (!busy && !ld) begin
            state_r <= BPAT_S_HDR;
          end
        end
        default: state_r <= BPAT_S_HDR;
      endcase
    end
  end

  // body bytes pass straight through to the application
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      body_valid_o <= 1'b0;
      body_byte_o <= 8'h00;
    end else begin
      body_valid_o <= state_r == BPAT_S_BODY && rx_valid_i;
      if (state_r == BPAT_S_BODY && rx_valid_i) begin
        body_byte_o <= rx_byte_i;
      end
    end
  end

  // remembered offer for a following fetch; any other header drops it
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pend_r <= 8'h00;
      pend_v_r <= 1'b0;
    end else if (ld && ld_two && ld_b0 == `BPAT_PB_MORE) begin
      pend_r <= ld_b1;
      pend_v_r <= 1'b1;
    end else if (state_r == BPAT_S_DEC && dec_valid_i &&
                 hdr_ins_o != `BPAT_INS_GET_RESPONSE) begin
      pend_v_r <= 1'b0;
    end
  end

  // byte sender, outputs registered inside
  bpat_tx u_tx (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .load_i(ld),
    .first_i(ld_b0),
    .second_i(ld_b1),
    .two_i(ld_two),
    .busy_o(busy),
    .tx_valid_o(tx_valid_o),
    .tx_byte_o(tx_byte_o),
    .tx_ready_i(tx_ready_i)
  );
endmodule // bpat_core
`default_nettype wire

// ### hw/bpat_defs.svh
// constants of the character-mode command unit transport
`ifndef BPAT_DEFS_SVH
`define BPAT_DEFS_SVH
`define BPAT_HDR_LEN 3'h5
`define BPAT_SW1_OK 8'h90
`define BPAT_SW2_OK 8'h00
`define BPAT_SW1_BAD_PARAM 8'h6A
`define BPAT_SW2_BAD_PARAM 8'h86
`define BPAT_PB_MORE 8'h61
`define BPAT_PB_WRONG_LEN 8'h6C
`define BPAT_INS_GET_RESPONSE 8'hC0
`endif

// ### hw/bpat_pkg.sv
// types of the character-mode command unit transport
`default_nettype none
package bpat_pkg;
  // direction of the body data, decided by the application per command
  typedef enum logic [1:0] {
    BPAT_DIR_NONE = 2'b00,
    BPAT_DIR_OUT = 2'b01,
    BPAT_DIR_IN = 2'b10,
    BPAT_DIR_BOTH = 2'b11
  } bpat_dir_type;
  typedef enum logic [2:0] {
    BPAT_S_HDR = 3'b000,
    BPAT_S_DEC = 3'b001,
    BPAT_S_DATA = 3'b010,
    BPAT_S_BODY = 3'b011,
    BPAT_S_PROC = 3'b100,
    BPAT_S_FIN = 3'b101
  } bpat_state_type;
endpackage
`default_nettype wire

// ### hw/bpat_tx.sv
// one- or two-byte sender towards the terminal
`timescale 1ns/1ps
`default_nettype none
module bpat_tx (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // load side
  input wire logic load_i,
  input wire logic [7:0] first_i,
  input wire logic [7:0] second_i,
  input wire logic two_i,
  output logic busy_o,
  // link side
  output logic tx_valid_o,
  output logic [7:0] tx_byte_o,
  input wire logic tx_ready_i
);
  logic [7:0] second_r;
  logic two_r;

  // a load is ignored while busy, so the caller must wait for idle
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_valid_o <= 1'b0;
      tx_byte_o <= 8'h00;
      second_r <= 8'h00;
      two_r <= 1'b0;
      busy_o <= 1'b0;
    end else if (!busy_o && load_i) begin
      tx_valid_o <= 1'b1;
      tx_byte_o <= first_i;
      second_r <= second_i;
      two_r <= two_i;
      busy_o <= 1'b1;
    end else if (tx_valid_o && tx_ready_i) begin
      if (two_r) begin
        tx_byte_o <= second_r; // status pairs leave back to back
        two_r <= 1'b0;
      end else begin
        tx_valid_o <= 1'b0;
        busy_o <= 1'b0;
      end
    end
  end
endmodule // bpat_tx
`default_nettype wire

// ### sim/bpat_core_monitor.sv
// assertion checker on the card transport ports
`timescale 1ns/1ps
`default_nettype none
`include "bpat_defs.svh"
module bpat_core_monitor (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // watched ports
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_byte_i,
  input wire logic tx_valid_o,
  input wire logic [7:0] tx_byte_o,
  input wire logic tx_ready_i,
  input wire logic hdr_valid_o,
  input wire logic [7:0] hdr_ins_o,
  input wire logic dec_valid_i,
  input wire bpat_pkg::bpat_dir_type dec_dir_i,
  input wire logic dec_param_ok_i,
  input wire logic dec_normal_i,
  input wire logic [7:0] dec_sw1_i,
  input wire logic body_valid_o,
  input wire logic [7:0] body_byte_o
);
  import bpat_pkg::*;
  // one domain, so clock and reset are given once
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  property p_hdr; hdr_valid_o |=> !hdr_valid_o; endproperty
  a_hdr: assert property (p_hdr)
    else $error("header flag too long");
  property p_hold; tx_valid_o && !tx_ready_i |=> tx_valid_o
    && $stable(tx_byte_o); endproperty
  a_hold: assert property (p_hold)
    else $error("offered byte changed before taken");
  property p_none; dec_valid_i && dec_param_ok_i && dec_normal_i
    && dec_dir_i == BPAT_DIR_NONE
    |=> tx_valid_o && tx_byte_o == `BPAT_SW1_OK; endproperty
  a_none: assert property (p_none)
    else $error("no-data command not ended by status");
  property p_bad; dec_valid_i && !dec_param_ok_i |=> tx_valid_o
    && tx_byte_o == `BPAT_SW1_BAD_PARAM; endproperty
  a_bad: assert property (p_bad)
    else $error("bad parameter first byte wrong");
  property p_bad2; dec_valid_i && !dec_param_ok_i ##1 tx_ready_i
    |=> tx_valid_o && tx_byte_o == `BPAT_SW2_BAD_PARAM; endproperty
  a_bad2: assert property (p_bad2)
    else $error("bad parameter second byte wrong");
  property p_abn; dec_valid_i && dec_param_ok_i && !dec_normal_i
    |=> tx_valid_o && tx_byte_o == $past(dec_sw1_i); endproperty
  a_abn: assert property (p_abn)
    else $error("abnormal status not sent alone");
  property p_ins; dec_valid_i && dec_param_ok_i && dec_normal_i
    && dec_dir_i[1] |=> tx_valid_o && tx_byte_o == hdr_ins_o; endproperty
  a_ins: assert property (p_ins)
    else $error("procedure byte differs from instruction");
  property p_body; body_valid_o |-> $past(rx_valid_i)
    && body_byte_o == $past(rx_byte_i); endproperty
  a_body: assert property (p_body)
    else $error("body byte not the one received");
endmodule // bpat_core_monitor
`default_nettype wire

// ### sim/bpat_term_model.sv
// terminal model: sends command bytes, accepts card bytes
`timescale 1ns/1ps
`default_nettype none
module bpat_term_model (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // link
  output logic rx_valid_o,
  output logic [7:0] rx_byte_o,
  output logic tx_ready_o,
  input wire logic tx_valid_i,
  input wire logic [7:0] tx_byte_i,
  // pacing
  input wire logic slow_i
);
  // slow mode stalls every other cycle so the card must hold its byte
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) tx_ready_o <= 1'b0;
    else tx_ready_o <= slow_i ? ~tx_ready_o : 1'b1;
  end
  initial begin
    rx_valid_o = 1'b0;
    rx_byte_o = 8'h00;
  end
  // one byte a pulse; idle data is inverted so stale values never match
  task automatic put(input logic [7:0] b);
    @(posedge sys_clk_i);
    rx_valid_o <= 1'b1;
    rx_byte_o <= b;
    @(posedge sys_clk_i);
    rx_valid_o <= 1'b0;
    rx_byte_o <= ~b;
  endtask
  // take one card byte at the edge where valid meets ready
  task automatic take(output logic [7:0] b);
    b = 'x;
    for (int i = 0; i < 200; i++) begin
      @(posedge sys_clk_i);
      if (tx_valid_i && tx_ready_o) begin
        b = tx_byte_i;
        break;
      end
    end
  endtask
endmodule // bpat_term_model
`default_nettype wire

// ### sim/tb_top.sv
// self-checking bench: card transport against the terminal model
`timescale 1ns/1ps
`default_nettype none
`include "bpat_defs.svh"
module tb_top;
  import bpat_pkg::*;
  logic clk, rst_n, slow, rxv, txv, txr, hv, rq, rdv, bv, dv, ok, nrm;
  logic dnv, dnn;
  logic [7:0] rxb, txb, ins, rdb, bb, av, s1, s2, dav, ds1, ds2;
  logic [7:0] cla, p1o, p2o, p3o;
  int n_body;
  bpat_dir_type dir;
  int n_mismatch = 0;
  int checks_done = 0;
  bpat_core uut (.sys_clk_i(clk), .rst_n_i(rst_n), .rx_valid_i(rxv),
    .rx_byte_i(rxb), .tx_valid_o(txv), .tx_byte_o(txb), .tx_ready_i(txr),
    .hdr_valid_o(hv), .hdr_cla_o(cla), .hdr_ins_o(ins), .hdr_p1_o(p1o),
    .hdr_p2_o(p2o), .hdr_p3_o(p3o), .dec_valid_i(dv), .dec_dir_i(dir),
    .dec_param_ok_i(ok), .dec_normal_i(nrm), .dec_avail_i(av),
    .dec_sw1_i(s1), .dec_sw2_i(s2), .rd_req_o(rq), .rd_valid_i(rdv),
    .rd_byte_i(rdb), .body_valid_o(bv), .body_byte_o(bb),
    .done_valid_i(dnv), .done_normal_i(dnn), .done_avail_i(dav),
    .done_sw1_i(ds1), .done_sw2_i(ds2));
  bpat_term_model term (.sys_clk_i(clk), .rst_n_i(rst_n), .rx_valid_o(rxv),
    .rx_byte_o(rxb), .tx_ready_o(txr), .tx_valid_i(txv), .tx_byte_i(txb),
    .slow_i(slow));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // application data source: answers each request one cycle later;
  // it also counts body pulses so a lost or doubled byte shows up
  always @(posedge clk) begin
    if (!rst_n) begin
      rdv <= 1'b0;
      rdb <= 8'hA0;
      n_body <= 0;
    end else begin
      rdv <= rq;
      if (rq) rdb <= rdb + 8'h01;
      if (bv) n_body <= n_body + 1;
    end
  end
  task automatic end_of_test;
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, e);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic exp(input logic [7:0] e);
    logic [7:0] g;
    term.take(g);
    chk(g, e);
  endtask
  task automatic data(input logic [7:0] b, input int n);
    for (int k = 1; k <= n; k++) exp(b + 8'(k));
  endtask
  // header, then the application decision once the header flag is seen
  task automatic cmd(input logic [7:0] i, p3, input bpat_dir_type d,
      input logic k, n, input logic [7:0] a, x, y);
    logic [7:0] h[5];
    int w;
    h = '{8'h80, i, 8'h01, 8'h02, p3};
    w = 0;
    repeat (3) @(posedge clk);
    foreach (h[j]) term.put(h[j]);
    do @(posedge clk); while (!hv && ++w < 20);
    chk({7'h00, hv}, 8'h01);
    chk(cla, 8'h80);
    chk(ins, i);
    chk(p1o, 8'h01);
    chk(p2o, 8'h02);
    chk(p3o, p3);
    {dv, ok, nrm} <= {1'b1, k, n};
    dir <= d;
    {av, s1, s2} <= {a, x, y};
    @(posedge clk);
    dv <= 1'b0;
  endtask
  task automatic fin(input logic n, input logic [7:0] a, x, y);
    @(posedge clk);
    {dnv, dnn, dav, ds1, ds2} <= {1'b1, n, a, x, y};
    @(posedge clk);
    dnv <= 1'b0;
  endtask
  task automatic t_none;
    cmd(8'h20, 8'h00, BPAT_DIR_NONE, 1, 1, 8'h00, 8'h00, 8'h00);
    exp(`BPAT_SW1_OK);
    exp(`BPAT_SW2_OK);
  endtask
  task automatic t_param;
    bpat_dir_type d[3] = '{BPAT_DIR_NONE, BPAT_DIR_OUT, BPAT_DIR_IN};
    foreach (d[j]) begin
      cmd(8'hD6, 8'h0B, d[j], 0, 1, 8'h0B, 8'h00, 8'h00);
      exp(`BPAT_SW1_BAD_PARAM);
      exp(`BPAT_SW2_BAD_PARAM);
    end
  endtask
  task automatic t_read;
    logic [7:0] p[2] = '{8'h00, 8'h15};
    logic [7:0] b;
    b = rdb;
    slow <= 1'b1;
    cmd(8'hB0, 8'h03, BPAT_DIR_OUT, 1, 1, 8'h03, 8'h00, 8'h00);
    exp(8'hB0);
    data(b, 3);
    exp(`BPAT_SW1_OK);
    exp(`BPAT_SW2_OK);
    slow <= 1'b0;
    cmd(8'hB0, 8'h03, BPAT_DIR_OUT, 1, 0, 8'h03, 8'h62, 8'h83);
    exp(8'h62);
    exp(8'h83);
    foreach (p[j]) begin
      cmd(8'hB0, p[j], BPAT_DIR_OUT, 1, 1, 8'h0B, 8'h00, 8'h00);
      exp(`BPAT_PB_WRONG_LEN);
      exp(8'h0B);
    end
    b = rdb;
    cmd(8'hB0, 8'h02, BPAT_DIR_OUT, 1, 1, 8'h05, 8'h00, 8'h00);
    exp(8'hB0);
    data(b, 2);
    exp(`BPAT_PB_MORE);
    exp(8'h03);
  endtask
  // body commands: status must wait for the application's end signal
  task automatic t_body;
    logic [7:0] b;
    cmd(8'hD6, 8'h02, BPAT_DIR_IN, 1, 1, 8'h00, 8'h00, 8'h00);
    exp(8'hD6);
    term.put(8'hAA);
    term.put(8'h55);
    repeat (4) @(posedge clk);
    chk({7'h00, txv}, 8'h00);
    chk(bb, 8'h55);
    chk(8'(n_body), 8'h02);
    fin(1, 8'h00, 8'h00, 8'h00);
    exp(`BPAT_SW1_OK);
    exp(`BPAT_SW2_OK);
    cmd(8'h88, 8'h01, BPAT_DIR_BOTH, 1, 1, 8'h00, 8'h00, 8'h00);
    exp(8'h88);
    term.put(8'h3C);
    fin(1, 8'h04, 8'h00, 8'h00);
    exp(`BPAT_PB_MORE);
    exp(8'h04);
    b = rdb;
    cmd(`BPAT_INS_GET_RESPONSE, 8'h04, BPAT_DIR_OUT, 1, 1, 8'h00, 8'h00,
      8'h00);
    exp(`BPAT_INS_GET_RESPONSE);
    data(b, 4);
    exp(`BPAT_SW1_OK);
    exp(`BPAT_SW2_OK);
    cmd(8'h88, 8'h01, BPAT_DIR_BOTH, 1, 1, 8'h00, 8'h00, 8'h00);
    exp(8'h88);
    term.put(8'h3C);
    fin(0, 8'h04, 8'h62, 8'h83);
    exp(8'h62);
    exp(8'h83);
    cmd(`BPAT_INS_GET_RESPONSE, 8'h00, BPAT_DIR_OUT, 1, 1, 8'h0B, 8'h00,
      8'h00);
    exp(`BPAT_PB_WRONG_LEN);
    exp(8'h0B);
    // an error status after the body: the terminal gives up, no fetch
    cmd(8'h88, 8'h01, BPAT_DIR_BOTH, 1, 1, 8'h00, 8'h00, 8'h00);
    exp(8'h88);
    term.put(8'h3C);
    fin(0, 8'h00, 8'h6F, 8'h00);
    exp(8'h6F);
    exp(8'h00);
    repeat (4) @(posedge clk);
    chk({7'h00, txv}, 8'h00);
  endtask
  // watchdog well beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    end_of_test();
  end
  initial begin
    rst_n = 1'b0;
    {slow, dv, ok, nrm, dnv, dnn} = '0;
    {av, s1, s2, dav, ds1, ds2} = '0;
    dir = BPAT_DIR_NONE;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    t_none();
    t_param();
    t_read();
    t_body();
    end_of_test();
  end
endmodule // tb_top
bind bpat_core bpat_core_monitor mon (.sys_clk_i(sys_clk_i),
  .rst_n_i(rst_n_i), .rx_valid_i(rx_valid_i), .rx_byte_i(rx_byte_i),
  .tx_valid_o(tx_valid_o), .tx_byte_o(tx_byte_o), .tx_ready_i(tx_ready_i),
  .hdr_valid_o(hdr_valid_o), .hdr_ins_o(hdr_ins_o),
  .dec_valid_i(dec_valid_i), .dec_dir_i(dec_dir_i),
  .dec_param_ok_i(dec_param_ok_i), .dec_normal_i(dec_normal_i),
  .dec_sw1_i(dec_sw1_i), .body_valid_o(body_valid_o),
  .body_byte_o(body_byte_o));
`default_nettype wire
